/* design/lio_apd_pkg.sv */
// constants, field layouts and carrier types of the legacy i/o power manager
package lio_apd_pkg;

  // floppy register offsets
  localparam logic [7:0] OFF_STATUS_A   = 8'h00;
  localparam logic [7:0] OFF_STATUS_B   = 8'h01;
  localparam logic [7:0] OFF_DOR        = 8'h02;
  localparam logic [7:0] OFF_MSR_DSR    = 8'h04;
  localparam logic [7:0] OFF_DATA       = 8'h05;
  localparam logic [7:0] OFF_DIR_CCR    = 8'h07;
  // power management registers
  localparam logic [7:0] OFF_DRIVE_MODE = 8'h10;
  localparam logic [7:0] OFF_APD_CFG    = 8'h11;
  localparam logic [7:0] OFF_DIRECT_CFG = 8'h12;
  localparam logic [7:0] OFF_PP_CFG     = 8'h13;
  localparam logic [7:0] OFF_ECR        = 8'h14;
  localparam logic [7:0] OFF_PM_STATUS  = 8'h15;

  // field positions
  localparam int DOR_MOTOR_LO  = 4;
  localparam int DOR_NRESET    = 2;
  localparam int DSR_SW_RESET  = 7;
  localparam int DSR_POWERDOWN = 6;
  localparam int MODE_SHUTDOWN = 5;
  localparam int APD_FDC       = 0;
  localparam int APD_PP        = 3;
  localparam int APD_UART_TX   = 4;
  localparam int APD_UART_RX   = 5;
  localparam int DIR_FDC       = 0;
  localparam int DIR_PP        = 3;
  localparam int DIR_UART      = 4;
  localparam int ECR_MODE_LO   = 5;

  // reset values
  localparam logic [7:0] DOR_RESET      = 8'h00;
  localparam logic [7:0] MSR_IDLE       = 8'h80;

  // parallel port modes
  localparam logic [1:0] PPC_SPP     = 2'h0;
  localparam logic [1:0] PPC_EPP     = 2'h1;
  localparam logic [1:0] PPC_ECP     = 2'h2;
  localparam logic [1:0] PPC_ECP_EPP = 2'h3;
  localparam logic [2:0] ECR_SPP     = 3'h0;
  localparam logic [2:0] ECR_BYTE    = 3'h1;
  localparam logic [2:0] ECR_EPP     = 3'h4;

  // timing
  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned APD_TIME_US   = 10000;
  localparam int unsigned APD_TIMER_CYC = APD_TIME_US * CLK_MHZ;
  localparam int          TMR_W         = 21;

  typedef enum logic [1:0] {APD_OFF, APD_WAIT, APD_DOWN} lio_apd_st_t;

  // drive-side outputs that tristate in powerdown (active low except gate)
  typedef struct packed {
    logic [1:0] motor_on_out;
    logic [1:0] drive_select_out;
    logic       write_data_out;
    logic       write_gate_out;
  } lio_fdd_sw_t;

  // drive-side outputs that stay driven
  typedef struct packed {
    logic       step_direction_out;
    logic       step_pulse_out;
    logic       head_select_out;
    logic [1:0] density_select_out;
  } lio_fdd_act_t;

  // drive inputs
  typedef struct packed {
    logic read_data_in;
    logic write_protect_in;
    logic track_zero_in;
    logic index_pulse_in;
    logic disk_changed_in;
  } lio_fdd_in_t;

endpackage

/* design/lio_apd.sv */
// auto power management for floppy, serial and parallel blocks
// Notes on behaviour
// - dor, dsr, ccr writes and status reads stay asleep
// - msr read or data access wakes floppy
// - motor bit or software reset wakes floppy
// - host bus port keeps working while asleep
// - motor, select, write pins tristate; inputs stay
// - step, direction, head, density, power-off stay driven
// - shutdown bit forces power-off output high
// - auto enable plus powerdown drives power-off high
// - otherwise power-off follows dsr powerdown bit
// - serial auto and direct powerdown enables
// - transmitter sleeps when buffer and shifter empty
// - receiver sleeps when fifo empty and idle
// - ring indicator still reported while asleep
// - transmit buffer write wakes transmitter
// - receive input change wakes receiver
// - parallel auto enable gates ecp/epp powerdown
// - epp sleeps unless enabled and selected
// - ecp sleeps unless enabled and selected
// - parallel state follows mode changes each cycle
// - floppy sleeps after idle conditions and timer
// - wake restarts the powerdown timer
// - dsr powerdown overrides, then auto resumes
// - writes retained, reads true while asleep
`timescale 1ns/10ps
module lio_apd
  import lio_apd_pkg::*;
#(
  parameter int unsigned APD_CYC = APD_TIMER_CYC
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   rstn_i,
  input  wire logic [7:0]             addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [7:0]             rdata_o,
  input  wire logic [7:0]             status_a_i,
  input  wire logic [7:0]             status_b_i,
  input  wire logic [7:0]             main_status_i,
  input  wire logic [7:0]             data_rd_i,
  input  wire logic [7:0]             drive_input_i,
  input  wire logic                   fdc_int_i,
  input  wire logic                   head_unload_done_i,
  input  wire lio_apd_pkg::lio_fdd_sw_t  fdd_core_sw_i,
  input  wire lio_apd_pkg::lio_fdd_act_t fdd_core_act_i,
  input  wire lio_apd_pkg::lio_fdd_in_t  fdd_pins_i,
  output lio_apd_pkg::lio_fdd_in_t    fdd_pins_o,
  output lio_apd_pkg::lio_fdd_sw_t    fdd_sw_o,
  output logic                        fdd_sw_oe_o,
  output lio_apd_pkg::lio_fdd_act_t   fdd_act_o,
  output logic                        drive_power_off_out_o,
  output logic                        fdc_pd_o,
  output logic                        fdc_data_rd_o,
  output logic                        fdc_data_wr_o,
  output logic      [7:0]             fdc_wdata_o,
  output logic                        fdc_soft_reset_o,
  output logic      [1:0]             rate_sel_o,
  input  wire logic                   tx_hold_empty_i,
  input  wire logic                   tx_shift_empty_i,
  input  wire logic                   tx_buf_write_i,
  input  wire logic                   rx_fifo_empty_i,
  input  wire logic                   rx_idle_i,
  input  wire logic                   rxd_pin_i,
  input  wire logic                   ring_pin_i,
  output logic                        uart_tx_pd_o,
  output logic                        uart_rx_pd_o,
  output logic                        ring_event_o,
  output logic                        epp_pd_o,
  output logic                        ecp_pd_o
);
  import lio_apd_pkg::*;

  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(APD_CYC - 1);

  typedef struct packed {
    lio_apd_st_t  apd;
    logic [TMR_W-1:0] tmr;
    logic [7:0]   floppy_drive_output_ctrl;
    logic         dsr_pd;
    logic [7:0]   floppy_config_ctrl;
    logic [7:0]   drive_mode;
    logic [7:0]   apd_cfg;
    logic [7:0]   direct_cfg;
    logic [7:0]   pp_cfg;
    logic [7:0]   ecr;
    logic [7:0]   rdata;
    logic [1:0]   rxd_sync;
    logic         rxd_last;
    logic [1:0]   ring_sync;
    logic         ring_last;
    lio_fdd_in_t  in_meta;
    lio_fdd_in_t  in_sync;
    lio_fdd_sw_t  sw;
    logic         sw_oe;
    lio_fdd_act_t act;
    logic         drive_power_off_out;
    logic         fdc_pd;
    logic         data_rd;
    logic         data_wr;
    logic [7:0]   wdata;
    logic         soft_reset;
    logic         tx_pd;
    logic         rx_pd;
    logic         ring_event;
    logic         epp_pd;
    logic         ecp_pd;
  } lio_state_t;

  lio_state_t s;
  lio_state_t next_s;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  logic wr_dor;
  logic wr_dsr;
  logic rd_msr;
  logic acc_data;
  logic sw_reset_req;
  logic wake;
  logic apd_en;
  logic idle_ok;
  logic rxd_now;
  logic tx_en;
  logic rx_en;
  logic pp_en;
  logic ecp_mode;
  logic epp_cfg;
  logic ecp_cfg;
  logic [2:0] ecr_mode;
  logic fdc_pd_now;

  always_comb begin
    next_s = s;
    wr_dor = wr_i && hit(addr_i, OFF_DOR);
    wr_dsr = wr_i && hit(addr_i, OFF_MSR_DSR);
    rd_msr = rd_i && hit(addr_i, OFF_MSR_DSR);
    acc_data = (rd_i || wr_i) && hit(addr_i, OFF_DATA);
    // ordinary dor/dsr/ccr writes and status reads do not count as wake
    sw_reset_req = (wr_dor && !wdata_i[DOR_NRESET])
                || (wr_dsr && wdata_i[DSR_SW_RESET]);
    wake = rd_msr || acc_data || sw_reset_req
        || (wr_dor && (wdata_i[7:DOR_MOTOR_LO] != 4'h0));
    apd_en = s.apd_cfg[APD_FDC];
    idle_ok = (s.floppy_drive_output_ctrl[7:DOR_MOTOR_LO] == 4'h0) && (main_status_i == MSR_IDLE)
           && !fdc_int_i && head_unload_done_i;

    // registers keep what is written whatever the power state
    if (wr_dor) begin
      next_s.floppy_drive_output_ctrl = wdata_i;
    end
    if (wr_i && hit(addr_i, OFF_DIR_CCR)) begin
      next_s.floppy_config_ctrl = wdata_i;
    end
    if (wr_i && hit(addr_i, OFF_DRIVE_MODE)) begin
      next_s.drive_mode = wdata_i;
    end
    if (wr_i && hit(addr_i, OFF_APD_CFG)) begin
      next_s.apd_cfg = wdata_i;
    end
    if (wr_i && hit(addr_i, OFF_DIRECT_CFG)) begin
      next_s.direct_cfg = wdata_i;
    end
    if (wr_i && hit(addr_i, OFF_PP_CFG)) begin
      next_s.pp_cfg = wdata_i;
    end
    if (wr_i && hit(addr_i, OFF_ECR)) begin
      next_s.ecr = wdata_i;
    end

    // dsr powerdown overrides auto powerdown until a write or reset clears it
    if (wr_dsr) begin
      next_s.dsr_pd = wdata_i[DSR_POWERDOWN] && !wdata_i[DSR_SW_RESET];
    end else if (sw_reset_req) begin
      next_s.dsr_pd = 1'b0;
    end

    // auto powerdown sequencer
    case (s.apd)
      APD_OFF: begin
        next_s.tmr = '0;
        if (apd_en) begin
          next_s.apd = APD_WAIT;
        end
      end
      APD_WAIT: begin
        if (!apd_en) begin
          next_s.apd = APD_OFF;
          next_s.tmr = '0;
        end else if (wake) begin
          next_s.tmr = '0;
        end else if ((s.tmr == TMR_LAST) && idle_ok) begin
          next_s.apd = APD_DOWN;
        end else if (s.tmr != TMR_LAST) begin
          next_s.tmr = s.tmr + TMR_W'(1);
        end
      end
      APD_DOWN: begin
        if (!apd_en) begin
          next_s.apd = APD_OFF;
          next_s.tmr = '0;
        end else if (wake) begin
          next_s.apd = APD_WAIT;
          next_s.tmr = '0;
        end
      end
      default: begin
        next_s.apd = APD_OFF;
        next_s.tmr = '0;
      end
    endcase
    // leaving dsr powerdown makes the auto timer start over
    if (s.dsr_pd && !next_s.dsr_pd && apd_en) begin
      next_s.apd = APD_WAIT;
      next_s.tmr = '0;
    end

    fdc_pd_now = (next_s.apd == APD_DOWN) || next_s.dsr_pd
              || next_s.direct_cfg[DIR_FDC];
    next_s.fdc_pd = fdc_pd_now;

    // power-off pin priority: shutdown, then auto, then dsr bit
    if (next_s.drive_mode[MODE_SHUTDOWN]) begin
      next_s.drive_power_off_out = 1'b1;
    end else if (next_s.apd_cfg[APD_FDC]) begin
      next_s.drive_power_off_out = (next_s.apd == APD_DOWN);
    end else begin
      next_s.drive_power_off_out = next_s.dsr_pd;
    end

    // cable drivers: motor and select come from the dor
    next_s.sw.motor_on_out = ~next_s.floppy_drive_output_ctrl[5:4];
    next_s.sw.drive_select_out = {!(next_s.floppy_drive_output_ctrl[1:0] == 2'h1), !(next_s.floppy_drive_output_ctrl[1:0] == 2'h0)};
    next_s.sw.write_data_out = fdd_core_sw_i.write_data_out;
    next_s.sw.write_gate_out = fdd_core_sw_i.write_gate_out;
    next_s.sw_oe = !fdc_pd_now;
    next_s.act = fdd_core_act_i;
    // drive inputs stay inputs, synchronised for the core
    next_s.in_meta = fdd_pins_i;
    next_s.in_sync = s.in_meta;

    // floppy core strobes
    next_s.data_rd = rd_i && hit(addr_i, OFF_DATA);
    next_s.data_wr = wr_i && hit(addr_i, OFF_DATA);
    next_s.wdata = wr_i ? wdata_i : s.wdata;
    next_s.soft_reset = sw_reset_req;

    // host port answers in every power state with true status
    next_s.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        OFF_STATUS_A:   next_s.rdata = status_a_i;
        OFF_STATUS_B:   next_s.rdata = status_b_i;
        OFF_DOR:        next_s.rdata = s.floppy_drive_output_ctrl;
        OFF_MSR_DSR:    next_s.rdata = main_status_i;
        OFF_DATA:       next_s.rdata = data_rd_i;
        OFF_DIR_CCR:    next_s.rdata = drive_input_i;
        OFF_DRIVE_MODE: next_s.rdata = s.drive_mode;
        OFF_APD_CFG:    next_s.rdata = s.apd_cfg;
        OFF_DIRECT_CFG: next_s.rdata = s.direct_cfg;
        OFF_PP_CFG:     next_s.rdata = s.pp_cfg;
        OFF_ECR:        next_s.rdata = s.ecr;
        OFF_PM_STATUS:  next_s.rdata = {2'h0, s.ecp_pd, s.epp_pd, s.rx_pd, s.tx_pd,
                                        s.dsr_pd, s.apd == APD_DOWN};
        default:        next_s.rdata = 8'h00;
      endcase
    end

    // serial: pins are synchronised, edge logic reads the second stage only
    next_s.rxd_sync = {s.rxd_sync[0], rxd_pin_i};
    next_s.ring_sync = {s.ring_sync[0], ring_pin_i};
    rxd_now = s.rxd_sync[1];
    next_s.rxd_last = rxd_now;
    next_s.ring_last = s.ring_sync[1];
    // ring detection is never gated by powerdown
    next_s.ring_event = s.ring_sync[1] != s.ring_last;
    tx_en = s.apd_cfg[APD_UART_TX];
    rx_en = s.apd_cfg[APD_UART_RX];
    if (tx_buf_write_i) begin
      next_s.tx_pd = 1'b0;
    end else if (tx_en && tx_hold_empty_i && tx_shift_empty_i) begin
      next_s.tx_pd = 1'b1;
    end else if (!tx_en) begin
      next_s.tx_pd = 1'b0;
    end
    if (rxd_now != s.rxd_last) begin
      next_s.rx_pd = 1'b0;
    end else if (rx_en && rx_fifo_empty_i && rx_idle_i) begin
      next_s.rx_pd = 1'b1;
    end else if (!rx_en) begin
      next_s.rx_pd = 1'b0;
    end
    if (s.direct_cfg[DIR_UART]) begin
      next_s.tx_pd = 1'b1;
      next_s.rx_pd = 1'b1;
    end

    // parallel: recomputed every cycle, so mode changes take effect at once
    pp_en = s.apd_cfg[APD_PP];
    ecr_mode = s.ecr[7:ECR_MODE_LO];
    epp_cfg = (s.pp_cfg[1:0] == PPC_EPP) || (s.pp_cfg[1:0] == PPC_ECP_EPP);
    ecp_cfg = (s.pp_cfg[1:0] == PPC_ECP) || (s.pp_cfg[1:0] == PPC_ECP_EPP);
    ecp_mode = ecp_cfg;
    next_s.epp_pd = s.direct_cfg[DIR_PP]
                 || (pp_en && (!epp_cfg || (ecp_mode && ecr_mode != ECR_EPP)));
    next_s.ecp_pd = s.direct_cfg[DIR_PP]
                 || (pp_en && (!ecp_cfg || ecr_mode == ECR_SPP
                     || ecr_mode == ECR_BYTE || ecr_mode == ECR_EPP));
  end

  // reset leaves everything awake; oe rises on the first edge after release
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s          <= '0;
      // receive line idles high: a zero here would fake an edge after reset
      s.rxd_sync <= 2'h3;
      s.rxd_last <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o               = s.rdata;
  assign fdd_pins_o            = s.in_sync;
  assign fdd_sw_o              = s.sw;
  assign fdd_sw_oe_o           = s.sw_oe;
  assign fdd_act_o             = s.act;
  assign drive_power_off_out_o = s.drive_power_off_out;
  assign fdc_pd_o              = s.fdc_pd;
  assign fdc_data_rd_o         = s.data_rd;
  assign fdc_data_wr_o         = s.data_wr;
  assign fdc_wdata_o           = s.wdata;
  assign fdc_soft_reset_o      = s.soft_reset;
  assign rate_sel_o            = s.floppy_config_ctrl[1:0];
  assign uart_tx_pd_o          = s.tx_pd;
  assign uart_rx_pd_o          = s.rx_pd;
  assign ring_event_o          = s.ring_event;
  assign epp_pd_o              = s.epp_pd;
  assign ecp_pd_o              = s.ecp_pd;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  dor_no_wake_a: assert property (s.apd == APD_DOWN && wr_dor && apd_en
      && wdata_i[7:4] == 4'h0 && wdata_i[DOR_NRESET] |=> s.apd == APD_DOWN)
    else $error("plain dor write woke the floppy");
  msr_wake_a: assert property (s.apd == APD_DOWN && apd_en && rd_msr
      |=> s.apd == APD_WAIT && s.tmr == '0)
    else $error("msr read did not wake the floppy");
  motor_wake_a: assert property (s.apd == APD_DOWN && apd_en && wr_dor
      && wdata_i[4] && !s.dsr_pd |=> s.apd == APD_WAIT)
    else $error("motor bit did not wake the floppy");
  pins_tristate_a: assert property (s.fdc_pd |-> !s.sw_oe)
    else $error("cable drivers enabled in powerdown");
  shutdown_fpd_a: assert property (s.drive_mode[MODE_SHUTDOWN]
      && $past(s.drive_mode[MODE_SHUTDOWN]) |-> drive_power_off_out_o)
    else $error("power-off low with shutdown set");
  dsr_fpd_a: assert property (!s.drive_mode[MODE_SHUTDOWN] && !s.apd_cfg[APD_FDC]
      |-> drive_power_off_out_o == s.dsr_pd)
    else $error("power-off does not follow dsr bit");
  tx_wake_a: assert property (tx_buf_write_i && !s.direct_cfg[DIR_UART]
      |=> !uart_tx_pd_o)
    else $error("transmit write did not wake transmitter");
  rx_wake_a: assert property (s.rx_pd && s.rxd_sync[1] != s.rxd_last
      && !s.direct_cfg[DIR_UART] |=> !uart_rx_pd_o)
    else $error("receive edge did not wake receiver");
  ecp_sleep_a: assert property (s.apd_cfg[APD_PP] && s.ecr[7:5] == ECR_EPP
      |=> ecp_pd_o)
    else $error("ecp awake in epp mode");
  enter_timer_a: assert property ($rose(s.apd == APD_DOWN)
      |-> $past(s.tmr) == TMR_LAST && $past(idle_ok))
    else $error("powerdown entered early");

  enter_pd_c: cover property (s.apd == APD_WAIT ##1 s.apd == APD_DOWN);
  wake_data_c: cover property (s.apd == APD_DOWN && acc_data ##1 s.apd == APD_WAIT);
  rx_cycle_c: cover property (s.rx_pd ##1 !s.rx_pd);
  dsr_exit_c: cover property (s.dsr_pd && apd_en ##1 !s.dsr_pd);

endmodule

/* verification/lio_apd_host.sv */
// host register-bus model for the legacy i/o power manager
`timescale 1ns/10ps
module lio_apd_host (
  input  wire logic       core_clk_i,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o,
  input  wire logic [7:0] rdata_i
);
  initial begin
    addr_o  = 8'hFF;
    wdata_o = 8'hFF;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end
  // released lines show the inverse, so a stale value cannot pass for a decode
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge core_clk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge core_clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    @(posedge core_clk_i);
    d = rdata_i;
  endtask
endmodule

/* verification/lio_apd_tb.sv */
// self-checking bench for the legacy i/o power manager
`timescale 1ns/10ps
module lio_apd_tb;
  import lio_apd_pkg::*;
  // short powerdown timer keeps the run brief
  localparam int unsigned CYC = 8;
  logic         clk, rstn, wr, rd, fdc_int, hud, sw_oe, drive_power_off_out, fdc_pd;
  logic         tx_he, tx_se, tx_wr, rx_fe, rx_idle, rxd, ring;
  logic         tx_pd, rx_pd, ring_ev, epp_pd, ecp_pd;
  logic [7:0]   addr, wdata, rdata, stat_a, din, floppy_main_status, fwd;
  logic         d_rd, d_wr, s_rst;
  logic [1:0]   rate_sel;
  lio_fdd_sw_t  core_sw, sw_out;
  lio_fdd_act_t core_act, act_out;
  lio_fdd_in_t  pins, pins_out;
  int           n_mismatch, cmp_count;

  lio_apd_host u_host (.core_clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
    .rd_o(rd), .rdata_i(rdata));
  lio_apd #(.APD_CYC(CYC)) u_dut (
    .core_clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .status_a_i(stat_a), .status_b_i(8'h3C),
    .main_status_i(floppy_main_status), .data_rd_i(8'h77), .drive_input_i(din), .fdc_int_i(fdc_int),
    .head_unload_done_i(hud), .fdd_core_sw_i(core_sw), .fdd_core_act_i(core_act),
    .fdd_pins_i(pins), .fdd_pins_o(pins_out), .fdd_sw_o(sw_out), .fdd_sw_oe_o(sw_oe),
    .fdd_act_o(act_out), .drive_power_off_out_o(drive_power_off_out), .fdc_pd_o(fdc_pd),
    .fdc_data_rd_o(d_rd), .fdc_data_wr_o(d_wr), .fdc_wdata_o(fwd), .fdc_soft_reset_o(s_rst),
    .rate_sel_o(rate_sel), .tx_hold_empty_i(tx_he), .tx_shift_empty_i(tx_se),
    .tx_buf_write_i(tx_wr), .rx_fifo_empty_i(rx_fe), .rx_idle_i(rx_idle),
    .rxd_pin_i(rxd), .ring_pin_i(ring), .uart_tx_pd_o(tx_pd), .uart_rx_pd_o(rx_pd),
    .ring_event_o(ring_ev), .epp_pd_o(epp_pd), .ecp_pd_o(ecp_pd));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // bounded wait; lo catches a timer that runs short
  task automatic wait_for(ref logic s, input logic v, input int lo);
    int n;
    n = 0;
    while (s !== v && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(8'(n >= lo && n < 40), 8'h01);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic t_regs;
    logic [7:0] v;
    u_host.wr_reg(OFF_PM_STATUS, 8'hFF);
    for (int a = 16; a < 23; a++) begin
      u_host.rd_reg(8'(a), v);
      chk(v, 8'h00);
    end
    chk(8'(sw_oe), 8'h01);
  endtask

  task automatic t_fpd;
    logic [7:0] v;
    u_host.wr_reg(OFF_DRIVE_MODE, 8'h20);
    @(posedge clk);
    chk(8'(drive_power_off_out), 8'h01);
    u_host.rd_reg(OFF_DRIVE_MODE, v);
    chk(v, 8'h20);
    u_host.wr_reg(OFF_MSR_DSR, 8'h40);
    u_host.wr_reg(OFF_DRIVE_MODE, 8'h00);
    @(posedge clk);
    chk(8'(drive_power_off_out), 8'h01);
    u_host.wr_reg(OFF_MSR_DSR, 8'h00);
    @(posedge clk);
    chk(8'(drive_power_off_out), 8'h00);
  endtask

  task automatic t_floppy;
    logic [7:0] v;
    logic [8:0] wk [6] = '{9'h004, 9'h105, 9'h005, 9'h102, 9'h102, 9'h104};
    logic [7:0] wd [6] = '{8'h00, 8'h33, 8'h00, 8'h14, 8'h00, 8'h80};
    logic [2:0] st [6] = '{3'h0, 3'h2, 3'h4, 3'h0, 3'h1, 3'h1};
    u_host.wr_reg(OFF_APD_CFG, 8'h01);
    repeat (CYC + 4) @(posedge clk);
    chk(8'(fdc_pd), 8'h00);
    fdc_int <= 1'b0;
    floppy_main_status     <= 8'h90;
    repeat (4) @(posedge clk);
    chk(8'(fdc_pd), 8'h00);
    floppy_main_status     <= 8'h80;
    hud     <= 1'b0;
    repeat (4) @(posedge clk);
    chk(8'(fdc_pd), 8'h00);
    hud     <= 1'b1;
    wait_for(fdc_pd, 1'b1, 0);
    chk(8'(sw_oe), 8'h00);
    chk(8'(drive_power_off_out), 8'h01);
    core_act <= 5'h15;
    core_sw  <= 6'h03;
    pins     <= 5'h0A;
    repeat (4) @(posedge clk);
    chk(8'(act_out), 8'h15);
    chk(8'(pins_out), 8'h0A);
    u_host.rd_reg(OFF_STATUS_A, v);
    chk(v, 8'h5A);
    u_host.rd_reg(OFF_DIR_CCR, v);
    chk(v, 8'hC3);
    u_host.rd_reg(OFF_STATUS_B, v);
    chk(v, 8'h3C);
    u_host.wr_reg(OFF_DOR, 8'h04);
    u_host.wr_reg(OFF_DIR_CCR, 8'h02);
    @(posedge clk);
    chk(8'(fdc_pd), 8'h01);
    chk(8'(rate_sel), 8'h02);
    for (int i = 0; i < 6; i++) begin
      if (wk[i][8]) begin
        u_host.wr_reg(wk[i][7:0], wd[i]);
        @(posedge clk);
      end else begin
        u_host.rd_reg(wk[i][7:0], v);
      end
      chk(8'({fdc_pd, sw_oe}), 8'h01);
      chk(8'({d_rd, d_wr, s_rst}), 8'(st[i]));
      if (i == 1) chk(fwd, 8'h33);
      if (i == 2) chk(v, 8'h77);
      if (i == 3) chk(8'(sw_out), 8'h2B);
      if (i == 0) chk(v, 8'h80);
      if (wd[i][4]) u_host.wr_reg(OFF_DOR, 8'h04);
      wait_for(fdc_pd, 1'b1, CYC - 2);
    end
    u_host.wr_reg(OFF_MSR_DSR, 8'h40);
    u_host.wr_reg(OFF_MSR_DSR, 8'h00);
    @(posedge clk);
    chk(8'(fdc_pd), 8'h00);
    wait_for(fdc_pd, 1'b1, CYC - 2);
    u_host.wr_reg(OFF_APD_CFG, 8'h00);
    @(posedge clk);
    chk(8'(drive_power_off_out), 8'h00);
  endtask

  task automatic t_serial;
    u_host.wr_reg(OFF_APD_CFG, 8'h30);
    repeat (2) @(posedge clk);
    chk(8'(tx_pd), 8'h00);
    chk(8'(rx_pd), 8'h01);
    tx_se <= 1'b1;
    repeat (2) @(posedge clk);
    chk(8'(tx_pd), 8'h01);
    tx_wr <= 1'b1;
    @(posedge clk);
    tx_wr <= 1'b0;
    @(posedge clk);
    chk(8'(tx_pd), 8'h00);
    rxd <= 1'b0;
    wait_for(rx_pd, 1'b0, 0);
    ring <= 1'b1;
    wait_for(ring_ev, 1'b1, 0);
    u_host.wr_reg(OFF_APD_CFG, 8'h00);
    u_host.wr_reg(OFF_DIRECT_CFG, 8'h10);
    repeat (2) @(posedge clk);
    chk(8'({tx_pd, rx_pd}), 8'h03);
    u_host.wr_reg(OFF_DIRECT_CFG, 8'h00);
  endtask

  task automatic t_par;
    logic [2:0] em [4] = '{3'h0, 3'h1, 3'h4, 3'h3};
    logic       ep, ec;
    u_host.wr_reg(OFF_APD_CFG, 8'h08);
    for (int p = 0; p < 4; p++) begin
      for (int e = 0; e < 4; e++) begin
        u_host.wr_reg(OFF_PP_CFG, 8'(p));
        u_host.wr_reg(OFF_ECR, {em[e], 5'h00});
        repeat (2) @(posedge clk);
        ep = !p[0] || (p[1] && em[e] != 3'h4);
        ec = !p[1] || em[e] inside {3'h0, 3'h1, 3'h4};
        chk(8'(epp_pd), 8'(ep));
        chk(8'(ecp_pd), 8'(ec));
      end
    end
    u_host.wr_reg(OFF_APD_CFG, 8'h00);
    repeat (2) @(posedge clk);
    chk(8'({epp_pd, ecp_pd}), 8'h00);
  endtask

  // reset in mid-run must put every decision back to awake
  task automatic t_reset;
    logic [7:0] v;
    u_host.wr_reg(OFF_APD_CFG, 8'h31);
    repeat (2) @(posedge clk);
    chk(8'({tx_pd, rx_pd}), 8'h03);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk(8'({fdc_pd, sw_oe, tx_pd, rx_pd}), 8'h00);
    rstn <= 1'b1;
    @(posedge clk);
    u_host.rd_reg(OFF_APD_CFG, v);
    chk(v, 8'h00);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    n_mismatch = 0;
    cmp_count  = 0;
    rstn       = 1'b0;
    stat_a     = 8'h5A;
    din        = 8'hC3;
    floppy_main_status        = 8'h80;
    fdc_int    = 1'b1;
    hud        = 1'b1;
    core_sw    = '0;
    core_act   = '0;
    pins       = '0;
    {tx_he, tx_se, tx_wr, rx_fe, rx_idle, rxd, ring} = 7'h4E;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_fpd();
    t_floppy();
    t_serial();
    t_par();
    t_reset();
    report_and_stop();
  end
endmodule
